// ===== core_sfr_flags_power_bank.sv
// special-function register bank: scratch, pointers, PWM flags, power and timer control
`include "sfr_bank_map.svh"
`default_nettype none
module core_sfr_flags_power_bank (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire sfr_bank_pkg::sfr_byte_t wdata,
	input wire logic wr,
	input wire logic rd,
	output sfr_bank_pkg::sfr_byte_t rdata,
	input wire logic pwm_zero_period_end,
	input wire logic pwm_group_period_end,
	input wire logic timer0_overflow,
	input wire logic timer1_overflow,
	input wire logic timer0_vector_ack,
	input wire logic timer1_vector_ack,
	input wire logic ext0_vector_ack,
	input wire logic ext1_vector_ack,
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	input wire logic wake_event,
	output logic pwm_zero_irq,
	output logic pwm_group_irq,
	output logic timer0_irq,
	output logic timer1_irq,
	output logic ext0_irq,
	output logic ext1_irq,
	output logic timer0_run,
	output logic timer1_run,
	output logic uart_baud_double,
	output sfr_bank_pkg::power_mode_t power_mode,
	output sfr_bank_pkg::sfr_byte_t stack_pointer,
	output logic [15:0] data_pointer
);
	import sfr_bank_pkg::*;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction

	// the bank never stalls: a strobe is served at the edge that sees it
	logic wr_scratch;
	logic wr_stack;
	logic wr_dptr_low;
	logic wr_dptr_high;
	logic wr_pie;
	logic wr_pif;
	logic wr_power;
	logic wr_timer_ctl;

	assign wr_scratch = wr && hit(addr, `ADDR_SCRATCH_BYTE);
	assign wr_stack = wr && hit(addr, `ADDR_STACK_POINTER);
	assign wr_dptr_low = wr && hit(addr, `ADDR_DATA_POINTER_LOW);
	assign wr_dptr_high = wr && hit(addr, `ADDR_DATA_POINTER_HIGH);
	assign wr_pie = wr && hit(addr, `ADDR_PWM_IRQ_ENABLE);
	assign wr_pif = wr && hit(addr, `ADDR_PWM_IRQ_FLAGS);
	assign wr_power = wr && hit(addr, `ADDR_POWER_CONTROL);
	assign wr_timer_ctl = wr && hit(addr, `ADDR_TIMER_EXTINT_CONTROL);

	// ----------------------------------------
	// plain storage bytes
	// ----------------------------------------
	sfr_byte_t scratch_byte;
	sfr_byte_t data_pointer_low;
	sfr_byte_t data_pointer_high;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scratch_byte <= `RST_SCRATCH_BYTE;
		end else if (wr_scratch) begin
			scratch_byte <= wdata; // RULE1
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stack_pointer <= `RST_STACK_POINTER;
		end else if (wr_stack) begin
			stack_pointer <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			data_pointer_low <= `RST_DATA_POINTER;
			data_pointer_high <= `RST_DATA_POINTER;
		end else begin
			if (wr_dptr_low) begin
				data_pointer_low <= wdata;
			end
			if (wr_dptr_high) begin
				data_pointer_high <= wdata;
			end
		end
	end

	assign data_pointer = {data_pointer_high, data_pointer_low};

	// ----------------------------------------
	// PWM interrupt enables and flags
	// ----------------------------------------
	logic pwm_group_irq_en;
	logic pwm_zero_irq_en;
	logic pwm_group_irq_flag;
	logic pwm_zero_irq_flag;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwm_group_irq_en <= `RST_FLAG_BIT;
			pwm_zero_irq_en <= `RST_FLAG_BIT;
		end else if (wr_pie) begin
			pwm_group_irq_en <= wdata[`BIT_PWM_GROUP];
			pwm_zero_irq_en <= wdata[`BIT_PWM_ZERO];
		end
	end

	// a written 0 clears, a written 1 keeps: BFh hits only the group flag, DFh only PWM0
	event_flag_cell u_pwm_group_flag (
		.clk(clk),
		.rst_n(rst_n),
		.set(pwm_group_period_end), // RULE4
		.clr(wr_pif && !wdata[`BIT_PWM_GROUP]), // RULE5 RULE20
		.wr(1'b0),
		.wdata(1'b0),
		.flag(pwm_group_irq_flag)
	);

	event_flag_cell u_pwm_zero_flag (
		.clk(clk),
		.rst_n(rst_n),
		.set(pwm_zero_period_end), // RULE6
		.clr(wr_pif && !wdata[`BIT_PWM_ZERO]), // RULE7 RULE20
		.wr(1'b0),
		.wdata(1'b0),
		.flag(pwm_zero_irq_flag)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwm_group_irq <= 1'b0;
			pwm_zero_irq <= 1'b0;
		end else begin
			pwm_group_irq <= pwm_group_irq_en & pwm_group_irq_flag; // RULE2
			pwm_zero_irq <= pwm_zero_irq_en & pwm_zero_irq_flag; // RULE3
		end
	end

	// ----------------------------------------
	// power control
	// ----------------------------------------
	logic user_flag_a;
	logic user_flag_b;
	logic stop_request;
	logic doze_request;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			uart_baud_double <= `RST_FLAG_BIT;
			user_flag_a <= `RST_FLAG_BIT;
			user_flag_b <= `RST_FLAG_BIT;
		end else if (wr_power) begin
			uart_baud_double <= wdata[`BIT_UART_BAUD_DOUBLE]; // RULE8
			user_flag_a <= wdata[`BIT_USER_FLAG_A]; // RULE9
			user_flag_b <= wdata[`BIT_USER_FLAG_B]; // RULE9
		end
	end

	// a wake event ends both low-power requests; a write in that cycle still wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stop_request <= `RST_FLAG_BIT;
			doze_request <= `RST_FLAG_BIT;
		end else if (wr_power) begin
			stop_request <= wdata[`BIT_STOP_REQUEST]; // RULE10
			doze_request <= wdata[`BIT_DOZE_REQUEST]; // RULE11
		end else if (wake_event) begin
			stop_request <= 1'b0;
			doze_request <= 1'b0;
		end
	end

	// stop outranks idle when both are asked together
	power_mode_t next_power_mode;

	always_comb begin
		case ({stop_request, doze_request})
			2'b10, 2'b11: next_power_mode = MODE_STOP; // RULE10
			2'b01: next_power_mode = MODE_DOZE; // RULE11
			2'b00: next_power_mode = MODE_RUN;
			default: next_power_mode = MODE_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			power_mode <= MODE_RUN;
		end else begin
			power_mode <= next_power_mode;
		end
	end

	// ----------------------------------------
	// timer and external interrupt control
	// ----------------------------------------
	logic timer0_overflow_flag;
	logic timer1_overflow_flag;
	logic ext0_trigger_select;
	logic ext1_trigger_select;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			timer1_run <= `RST_FLAG_BIT;
			timer0_run <= `RST_FLAG_BIT;
			ext1_trigger_select <= `RST_FLAG_BIT;
			ext0_trigger_select <= `RST_FLAG_BIT;
		end else if (wr_timer_ctl) begin
			timer1_run <= wdata[`BIT_TIMER1_RUN]; // RULE13
			timer0_run <= wdata[`BIT_TIMER0_RUN]; // RULE15
			ext1_trigger_select <= wdata[`BIT_EXT1_TRIGGER]; // RULE17
			ext0_trigger_select <= wdata[`BIT_EXT0_TRIGGER]; // RULE19
		end
	end

	// software may write a timer flag; an overflow or vector ack in that cycle outranks it
	event_flag_cell u_timer1_flag (
		.clk(clk),
		.rst_n(rst_n),
		.set(timer1_overflow), // RULE12
		.clr(timer1_vector_ack), // RULE12
		.wr(wr_timer_ctl),
		.wdata(wdata[`BIT_TIMER1_OVERFLOW]),
		.flag(timer1_overflow_flag)
	);

	event_flag_cell u_timer0_flag (
		.clk(clk),
		.rst_n(rst_n),
		.set(timer0_overflow), // RULE14
		.clr(timer0_vector_ack), // RULE14
		.wr(wr_timer_ctl),
		.wdata(wdata[`BIT_TIMER0_OVERFLOW]),
		.flag(timer0_overflow_flag)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			timer0_irq <= 1'b0;
			timer1_irq <= 1'b0;
		end else begin
			timer0_irq <= timer0_overflow_flag;
			timer1_irq <= timer1_overflow_flag;
		end
	end

	// ----------------------------------------
	// external interrupt pins
	// ----------------------------------------
	// pins are taken as synchronous; an asynchronous source needs a synchroniser ahead of this bank
	ext_irq_if ext0_if ();
	ext_irq_if ext1_if ();

	assign ext0_if.pin = ext_irq_pin_a;
	assign ext0_if.trig_sel = ext0_trigger_select;
	assign ext0_if.ack = ext0_vector_ack; // RULE18
	assign ext0_if.wr = wr_timer_ctl;
	assign ext0_if.wdata = wdata[`BIT_EXT0_EDGE];

	assign ext1_if.pin = ext_irq_pin_b;
	assign ext1_if.trig_sel = ext1_trigger_select;
	assign ext1_if.ack = ext1_vector_ack; // RULE16
	assign ext1_if.wr = wr_timer_ctl;
	assign ext1_if.wdata = wdata[`BIT_EXT1_EDGE];

	ext_irq_unit u_ext0 (
		.clk(clk),
		.rst_n(rst_n),
		.port_if(ext0_if.unit)
	);

	ext_irq_unit u_ext1 (
		.clk(clk),
		.rst_n(rst_n),
		.port_if(ext1_if.unit)
	);

	assign ext0_irq = ext0_if.req;
	assign ext1_irq = ext1_if.req;

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// unmapped offsets and reserved bits read as zero
	sfr_byte_t next_rdata;

	always_comb begin
		next_rdata = `RST_UNMAPPED_READ;
		if (hit(addr, `ADDR_SCRATCH_BYTE)) begin
			next_rdata = scratch_byte;
		end else if (hit(addr, `ADDR_STACK_POINTER)) begin
			next_rdata = stack_pointer;
		end else if (hit(addr, `ADDR_DATA_POINTER_LOW)) begin
			next_rdata = data_pointer_low;
		end else if (hit(addr, `ADDR_DATA_POINTER_HIGH)) begin
			next_rdata = data_pointer_high;
		end else if (hit(addr, `ADDR_PWM_IRQ_ENABLE)) begin
			next_rdata[`BIT_PWM_GROUP] = pwm_group_irq_en;
			next_rdata[`BIT_PWM_ZERO] = pwm_zero_irq_en;
		end else if (hit(addr, `ADDR_PWM_IRQ_FLAGS)) begin
			next_rdata[`BIT_PWM_GROUP] = pwm_group_irq_flag;
			next_rdata[`BIT_PWM_ZERO] = pwm_zero_irq_flag;
		end else if (hit(addr, `ADDR_POWER_CONTROL)) begin
			next_rdata[`BIT_UART_BAUD_DOUBLE] = uart_baud_double;
			next_rdata[`BIT_USER_FLAG_B] = user_flag_b;
			next_rdata[`BIT_USER_FLAG_A] = user_flag_a;
			next_rdata[`BIT_STOP_REQUEST] = stop_request;
			next_rdata[`BIT_DOZE_REQUEST] = doze_request;
		end else if (hit(addr, `ADDR_TIMER_EXTINT_CONTROL)) begin
			next_rdata[`BIT_TIMER1_OVERFLOW] = timer1_overflow_flag;
			next_rdata[`BIT_TIMER1_RUN] = timer1_run;
			next_rdata[`BIT_TIMER0_OVERFLOW] = timer0_overflow_flag;
			next_rdata[`BIT_TIMER0_RUN] = timer0_run;
			next_rdata[`BIT_EXT1_EDGE] = ext1_if.flag;
			next_rdata[`BIT_EXT1_TRIGGER] = ext1_trigger_select;
			next_rdata[`BIT_EXT0_EDGE] = ext0_if.flag;
			next_rdata[`BIT_EXT0_TRIGGER] = ext0_trigger_select;
		end
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= `RST_UNMAPPED_READ;
		end else if (rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= `RST_UNMAPPED_READ;
		end
	end
endmodule // core_sfr_flags_power_bank
`default_nettype wire

// ===== sfr_bank_map.svh
// offsets, field positions, reset values and codes of the flags and power register bank
//
// Function
// RULE1: scratch byte at 80h, read/write, resets 00h
// RULE2: enable bit 6 gates PWM1-PWM6 interrupt
// RULE3: enable bit 5 gates PWM0 interrupt
// RULE4: PWM1 period end sets flag bit 6
// RULE5: writing BFh clears PWM1-group flag
// RULE6: PWM0 period end sets flag bit 5
// RULE7: writing DFh clears PWM0 flag
// RULE8: power bit 7 doubles UART baud, resets 0
// RULE9: power bits 3,2 are plain user flags
// RULE10: writing 1 to power bit 1 stops
// RULE11: writing 1 to power bit 0 idles
// RULE12: timer1 overflow sets bit 7, vector clears
// RULE13: timer bit 6 runs timer 1
// RULE14: timer0 overflow sets bit 5, vector clears
// RULE15: timer bit 4 runs timer 0
// RULE16: pin b falling edge sets bit 3
// RULE17: bit 2 selects pin b level/edge
// RULE18: pin a falling edge sets bit 1
// RULE19: bit 0 selects pin a level/edge
// RULE20: PWM flag write: 0 clears, 1 keeps
// RULE21: hardware set beats clear in same cycle
`ifndef SFR_BANK_MAP_SVH
`define SFR_BANK_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_SCRATCH_BYTE 8'h80
`define ADDR_STACK_POINTER 8'h81
`define ADDR_DATA_POINTER_LOW 8'h82
`define ADDR_DATA_POINTER_HIGH 8'h83
`define ADDR_PWM_IRQ_ENABLE 8'h84
`define ADDR_PWM_IRQ_FLAGS 8'h85
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_TIMER_EXTINT_CONTROL 8'h88

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_SCRATCH_BYTE 8'h00
`define RST_STACK_POINTER 8'h07
`define RST_DATA_POINTER 8'h00
`define RST_FLAG_BIT 1'b0
`define RST_UNMAPPED_READ 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_PWM_GROUP 6
`define BIT_PWM_ZERO 5
`define BIT_UART_BAUD_DOUBLE 7
`define BIT_USER_FLAG_B 3
`define BIT_USER_FLAG_A 2
`define BIT_STOP_REQUEST 1
`define BIT_DOZE_REQUEST 0
`define BIT_TIMER1_OVERFLOW 7
`define BIT_TIMER1_RUN 6
`define BIT_TIMER0_OVERFLOW 5
`define BIT_TIMER0_RUN 4
`define BIT_EXT1_EDGE 3
`define BIT_EXT1_TRIGGER 2
`define BIT_EXT0_EDGE 1
`define BIT_EXT0_TRIGGER 0

// ----------------------------------------
// software clear codes for the PWM flags
// ----------------------------------------
`define CLR_PWM_GROUP 8'hBF
`define CLR_PWM_ZERO 8'hDF

`endif

// ===== sfr_bank_pkg.sv
// types shared by the flags and power register bank
`default_nettype none
package sfr_bank_pkg;
	typedef logic [7:0] sfr_byte_t;
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_DOZE = 2'b01,
		MODE_STOP = 2'b10
	} power_mode_t;
endpackage
`default_nettype wire

// ===== ext_irq_if.sv
// signals between the bank and one external interrupt pin unit
`default_nettype none
interface ext_irq_if;
	logic pin;
	logic trig_sel;
	logic ack;
	logic wr;
	logic wdata;
	logic flag;
	logic req;
	modport unit (input pin, input trig_sel, input ack, input wr, input wdata, output flag, output req);
	modport bank (output pin, output trig_sel, output ack, output wr, output wdata, input flag, input req);
endinterface
`default_nettype wire

// ===== event_flag_cell.sv
// one hardware-set flag with clear and software write; set has priority
`include "sfr_bank_map.svh"
`default_nettype none
module event_flag_cell (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic set,
	input wire logic clr,
	input wire logic wr,
	input wire logic wdata,
	output logic flag
);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag <= `RST_FLAG_BIT;
		end else if (set) begin
			flag <= 1'b1; // RULE21
		end else if (clr) begin
			flag <= 1'b0;
		end else if (wr) begin
			flag <= wdata;
		end
	end
endmodule // event_flag_cell
`default_nettype wire

// ===== ext_irq_unit.sv
// external interrupt pin: falling edge detect, edge flag and request level
`include "sfr_bank_map.svh"
`default_nettype none
module ext_irq_unit (
	input wire logic clk,
	input wire logic rst_n,
	ext_irq_if.unit port_if
);
	logic pin_prev;
	logic fall;

	assign fall = pin_prev & ~port_if.pin;

	// pin idles high so reset assumes high, no false edge after reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_prev <= 1'b1;
		end else begin
			pin_prev <= port_if.pin;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			port_if.flag <= `RST_FLAG_BIT;
		end else if (fall) begin
			port_if.flag <= 1'b1; // RULE16 RULE18 RULE21
		end else if (port_if.ack) begin
			port_if.flag <= 1'b0;
		end else if (port_if.wr) begin
			port_if.flag <= port_if.wdata;
		end
	end

	// level mode asks while the pin stays low, edge mode while the flag stands
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			port_if.req <= 1'b0;
		end else if (port_if.trig_sel) begin
			port_if.req <= port_if.flag; // RULE17 RULE19
		end else begin
			port_if.req <= ~port_if.pin; // RULE17 RULE19
		end
	end
endmodule // ext_irq_unit
`default_nettype wire

// ===== core_sfr_flags_power_bank_sva.sv
// bus-visible timing checks for the flags and power register bank
`default_nettype none
module core_sfr_flags_power_bank_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire sfr_bank_pkg::sfr_byte_t wdata,
	input wire logic wr,
	input wire logic rd,
	input wire sfr_bank_pkg::sfr_byte_t rdata,
	input wire logic timer0_overflow,
	input wire logic timer1_overflow,
	input wire logic timer0_vector_ack,
	input wire logic timer1_vector_ack,
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	input wire logic timer0_irq,
	input wire logic timer1_irq,
	input wire logic ext0_irq,
	input wire logic ext1_irq,
	input wire logic timer0_run,
	input wire logic timer1_run,
	input wire logic uart_baud_double,
	input wire sfr_bank_pkg::power_mode_t power_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	import sfr_bank_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// pin must stay low one more cycle so level mode agrees
	sequence fall_a;
		$fell(ext_irq_pin_a) ##1 !ext_irq_pin_a;
	endsequence
	sequence fall_b;
		$fell(ext_irq_pin_b) ##1 !ext_irq_pin_b;
	endsequence
	a_read_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not zero outside read slot");
	a_timer1_set: assert property (timer1_overflow |-> ##2 timer1_irq)
		else $error("timer1 overflow not flagged");
	a_timer1_ack_clear: assert property
		(timer1_vector_ack && !timer1_overflow && !(wr && addr == 8'h88) |-> ##2 !timer1_irq)
		else $error("timer1 flag kept after vector");
	a_timer0_set: assert property (timer0_overflow |-> ##2 timer0_irq)
		else $error("timer0 overflow not flagged");
	a_timer0_ack_clear: assert property
		(timer0_vector_ack && !timer0_overflow && !(wr && addr == 8'h88) |-> ##2 !timer0_irq)
		else $error("timer0 flag kept after vector");
	a_ext0_fall_irq: assert property (fall_a |=> ext0_irq)
		else $error("pin a fall gave no request");
	a_ext1_fall_irq: assert property (fall_b |=> ext1_irq)
		else $error("pin b fall gave no request");
	a_run1_write: assert property (wr && addr == 8'h88 && wdata[6] |=> timer1_run)
		else $error("timer1 run not set");
	a_run0_write: assert property (wr && addr == 8'h88 && !wdata[4] |=> !timer0_run)
		else $error("timer0 run not cleared");
	a_baud_write: assert property (wr && addr == 8'h87 && wdata[7] |=> uart_baud_double)
		else $error("baud double not set");
	a_stop_entry: assert property (wr && addr == 8'h87 && wdata[1] |-> ##2 power_mode == MODE_STOP)
		else $error("stop not entered");
	a_doze_entry: assert property
		(wr && addr == 8'h87 && wdata[1:0] == 2'b01 |-> ##2 power_mode == MODE_DOZE)
		else $error("idle not entered");
endmodule // core_sfr_flags_power_bank_sva
`default_nettype wire

// ===== sfr_core_master.sv
// processor-side model on the register bus
`default_nettype none
module sfr_core_master (
	input wire logic clk,
	input wire sfr_bank_pkg::sfr_byte_t rdata,
	output logic [7:0] addr,
	output sfr_bank_pkg::sfr_byte_t wdata,
	output logic wr,
	output logic rd
);
	timeunit 1ns;
	timeprecision 1ps;
	import sfr_bank_pkg::*;
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	// one-cycle strobes; the bank never stalls
	task automatic write_reg(input logic [7:0] a, input sfr_byte_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic read_reg(input logic [7:0] a, output sfr_byte_t d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
endmodule // sfr_core_master
`default_nettype wire

// ===== core_sfr_flags_power_bank_tb.sv
// self-checking bench for the flags and power register bank
`default_nettype none
module core_sfr_flags_power_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sfr_bank_pkg::*;
	logic clk;
	logic rst_n;
	logic [7:0] addr;
	sfr_byte_t wdata, rdata, stack_pointer;
	logic wr, rd;
	// events, acks, wake and the two pins (pins idle high)
	logic [10:0] ev;
	logic pwm_zero_irq, pwm_group_irq, timer0_irq, timer1_irq, ext0_irq, ext1_irq;
	logic timer0_run, timer1_run, uart_baud_double;
	power_mode_t power_mode;
	logic [15:0] data_pointer;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	core_sfr_flags_power_bank core_sfr_flags_power_bank_inst (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pwm_zero_period_end(ev[0]),
		.pwm_group_period_end(ev[1]), .timer0_overflow(ev[2]), .timer1_overflow(ev[3]),
		.timer0_vector_ack(ev[4]), .timer1_vector_ack(ev[5]), .ext0_vector_ack(ev[6]),
		.ext1_vector_ack(ev[7]), .wake_event(ev[8]), .ext_irq_pin_a(ev[9]), .ext_irq_pin_b(ev[10]),
		.pwm_zero_irq(pwm_zero_irq), .pwm_group_irq(pwm_group_irq), .timer0_irq(timer0_irq),
		.timer1_irq(timer1_irq), .ext0_irq(ext0_irq), .ext1_irq(ext1_irq), .timer0_run(timer0_run),
		.timer1_run(timer1_run), .uart_baud_double(uart_baud_double), .power_mode(power_mode),
		.stack_pointer(stack_pointer), .data_pointer(data_pointer));
	sfr_core_master sfr_core_master_inst (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// bench cycles stay far below this
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("TB: errors=%0d checks=%0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input sfr_byte_t exp);
		sfr_byte_t v;
		sfr_core_master_inst.read_reg(a, v);
		chk(v, exp);
	endtask
	task automatic wreg(input logic [7:0] a, input sfr_byte_t v);
		sfr_core_master_inst.write_reg(a, v);
	endtask
	task automatic set_ev(input int i, input logic v);
		@(posedge clk);
		ev[i] <= v;
	endtask
	task automatic pulse(input int i);
		set_ev(i, 1'b1);
		set_ev(i, 1'b0);
	endtask
	task automatic settle();
		@(posedge clk);
		#1;
	endtask
	task automatic test_reset_map();
		for (int a = 8'h80; a <= 8'h88; a++) rchk(8'(a), (a == 8'h81) ? 8'h07 : 8'h00);
		chk(stack_pointer, 8'h07);
		chk(data_pointer, 16'h0000);
	endtask
	task automatic test_storage();
		wreg(8'h80, 8'hA5);
		rchk(8'h80, 8'hA5);
		wreg(8'h82, 8'h34);
		wreg(8'h83, 8'h12);
		wreg(8'h81, 8'h3C);
		wreg(8'h86, 8'hFF);
		rchk(8'h86, 8'h00);
		chk(data_pointer, 16'h1234);
		chk(stack_pointer, 8'h3C);
	endtask
	task automatic test_pwm();
		wreg(8'h84, 8'h60);
		pulse(1);
		rchk(8'h85, 8'h40);
		chk(pwm_group_irq, 1'b1);
		pulse(0);
		rchk(8'h85, 8'h60);
		chk(pwm_zero_irq, 1'b1);
		wreg(8'h85, 8'hFF);
		rchk(8'h85, 8'h60);
		wreg(8'h85, 8'hBF);
		rchk(8'h85, 8'h20);
		wreg(8'h85, 8'hDF);
		rchk(8'h85, 8'h00);
		wreg(8'h84, 8'h00);
		pulse(1);
		pulse(0);
		rchk(8'h85, 8'h60);
		chk({pwm_group_irq, pwm_zero_irq}, 2'b00);
		fork
			pulse(1);
			wreg(8'h85, 8'h9F);
		join
		rchk(8'h85, 8'h40);
		wreg(8'h85, 8'h00);
	endtask
	task automatic test_power();
		wreg(8'h87, 8'h8C);
		rchk(8'h87, 8'h8C);
		chk(uart_baud_double, 1'b1);
		chk(power_mode, MODE_RUN);
		wreg(8'h87, 8'h01);
		settle();
		chk(power_mode, MODE_DOZE);
		pulse(8);
		settle();
		chk(power_mode, MODE_RUN);
		wreg(8'h87, 8'h02);
		settle();
		chk(power_mode, MODE_STOP);
		pulse(8);
		wreg(8'h87, 8'h00);
	endtask
	task automatic test_timer();
		wreg(8'h88, 8'h50);
		rchk(8'h88, 8'h50);
		chk({timer1_run, timer0_run}, 2'b11);
		pulse(3);
		rchk(8'h88, 8'hD0);
		chk(timer1_irq, 1'b1);
		pulse(5);
		rchk(8'h88, 8'h50);
		pulse(2);
		rchk(8'h88, 8'h70);
		chk(timer0_irq, 1'b1);
		pulse(4);
		rchk(8'h88, 8'h50);
		wreg(8'h88, 8'h00);
		rchk(8'h88, 8'h00);
		chk({timer1_run, timer0_run}, 2'b00);
	endtask
	task automatic test_ext();
		wreg(8'h88, 8'h05);
		set_ev(9, 1'b0);
		rchk(8'h88, 8'h07);
		chk(ext0_irq, 1'b1);
		pulse(6);
		set_ev(9, 1'b1);
		rchk(8'h88, 8'h05);
		set_ev(10, 1'b0);
		rchk(8'h88, 8'h0D);
		pulse(7);
		settle();
		chk(ext1_irq, 1'b0);
		wreg(8'h88, 8'h00);
		settle();
		chk(ext1_irq, 1'b1);
		set_ev(10, 1'b1);
		set_ev(9, 1'b0);
		settle();
		chk({ext1_irq, ext0_irq}, 2'b01);
		set_ev(9, 1'b1);
	endtask
	initial begin
		rst_n = 1'b0;
		ev = 11'h600;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		test_reset_map();
		test_storage();
		test_pwm();
		test_power();
		test_timer();
		test_ext();
		report_and_stop();
	end
endmodule // core_sfr_flags_power_bank_tb
bind core_sfr_flags_power_bank core_sfr_flags_power_bank_sva core_sfr_flags_power_bank_sva_inst (.clk(clk),
	.rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow), .timer0_vector_ack(timer0_vector_ack),
	.timer1_vector_ack(timer1_vector_ack), .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b),
	.timer0_irq(timer0_irq), .timer1_irq(timer1_irq), .ext0_irq(ext0_irq), .ext1_irq(ext1_irq),
	.timer0_run(timer0_run), .timer1_run(timer1_run), .uart_baud_double(uart_baud_double),
	.power_mode(power_mode));
`default_nettype wire
